// ---- logic/lcc_config_regs.sv ----
// common configuration register bank of the matrix LED driver, with its serial link
//
// Overview of operation
// - bit 12 of word 0 turns power saving on when one, off when zero, and resets to zero.
// - bits 14-13 of word 0 select power-saving-plus: off, or thresholds of 1/4, 1/2 or 7/8 of the segment length.
// - bit 15 of word 0 enables open LED removal when one and resets to zero.
// - bits 21-16 of word 0 give code plus one scan lines, 1 to 64, resetting to zero.
// - bits 24-22 of word 0 give 16 times code plus one subperiods, 16 to 128, resetting to zero.
// - bit 28 of word 0 picks the high multiplier range at zero and the low range at one, resetting to zero.
// - bits 32-29 of word 0 give a grayscale clock of code plus one times the serial clock, resetting to 0111b.
// - bits 38-36, 41-39 and 44-42 delay red, green and blue by code grayscale clocks, resetting to zero.
// - bit 47 of word 0 enables short LED caterpillar removal when one and resets to zero.
// - the segment length field gives 1024 cycles at code 1023 and 128 cycles for any other code.
// - the soft reset command AA80h returns both configuration words to their reset values.
`timescale 1ns/1ns
`default_nettype none
`include "lcc_map.svh"
module lcc_config_regs
	import lcc_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  resetn,
	input  wire logic  serClk,
	input  wire logic  serDataIn,
	output logic       serDataOut,
	output lcc_word_t  configWord0,
	output lcc_word_t  configWord1,
	output logic       powerSaveEnable,
	output logic [1:0] powerSavePlusSelect,
	output logic [10:0] powerSavePlusLimit,
	output logic       openLedRemovalEnable,
	output logic [6:0] scanLineCount,
	output logic [7:0] subperiodCount,
	output logic       multiplierRangeSelect,
	output logic [4:0] multiplierRatio,
	output logic [2:0] redGroupDelay,
	output logic [2:0] greenGroupDelay,
	output logic [2:0] blueGroupDelay,
	output logic       shortLedRemovalEnable,
	output logic [10:0] segmentCycleCount
);
	lcc_link_if linkBus ();

	lcc_serial_link u_link (
		.serClk     (serClk),
		.resetn     (resetn),
		.serDataIn  (serDataIn),
		.serDataOut (serDataOut),
		.bus        (linkBus.link)
	);

	lcc_word_t  word0_r, word0_nxt;
	lcc_word_t  word1_r, word1_nxt;
	logic       rstMeta_r, rstSync_r;
	logic       cmdMeta_r, cmdSync_r, cmdSeen_r;
	logic       ackTgl_r;
	logic       applied_r;
	logic       pubTgl_r;
	lcc_word_t  pubWord0_r, pubWord1_r;
	logic       psEn_r;
	logic [1:0] pspSel_r;
	logic [10:0] pspLimit_r;
	logic       openRm_r;
	logic [6:0] scanLines_r;
	logic [7:0] subperiods_r;
	logic       multRange_r;
	logic [4:0] multRatio_r;
	logic [2:0] dlyRed_r, dlyGreen_r, dlyBlue_r;
	logic       shortRm_r;
	logic [10:0] segCycles_r;

	// command arrival and decode
	wire        cmdEvent = (cmdSync_r != cmdSeen_r);
	wire        isWr0    = cmdEvent && (linkBus.cmdId == `LCC_CMD_WR_WORD0);
	wire        isWr1    = cmdEvent && (linkBus.cmdId == `LCC_CMD_WR_WORD1);
	wire        isSoft   = cmdEvent && (linkBus.cmdId == `LCC_CMD_SOFT_RESET);

	// word 1 bit 47 is read only and always zero; reserved bits are stored as written
	wire lcc_word_t wr1Masked = {1'b0, linkBus.cmdData[`LCC_W1_RO_BIT-1:0]};

	assign word0_nxt = isSoft ? `LCC_WORD0_RESET :
	                   isWr0  ? linkBus.cmdData : word0_r;
	assign word1_nxt = isSoft ? `LCC_WORD1_RESET :
	                   isWr1  ? wr1Masked : word1_r;

	// field decode from the stored words
	wire        fPsEn    = word0_r[`LCC_POWER_SAVE_ENABLE_BIT];
	wire [1:0]  fPsp     = word0_r[`LCC_PSP_HI:`LCC_PSP_LO];
	wire        fOpenRm  = word0_r[`LCC_OPEN_RM_BIT];
	wire [5:0]  fScan    = word0_r[`LCC_SCAN_HI:`LCC_SCAN_LO];
	wire [2:0]  fSubp    = word0_r[`LCC_SUBP_HI:`LCC_SUBP_LO];
	wire        fRange   = word0_r[`LCC_MULT_MODE_BIT];
	wire [3:0]  fMult    = word0_r[`LCC_MULT_HI:`LCC_MULT_LO];
	wire [2:0]  fDlyR    = word0_r[`LCC_DLY_R_HI:`LCC_DLY_R_LO];
	wire [2:0]  fDlyG    = word0_r[`LCC_DLY_G_HI:`LCC_DLY_G_LO];
	wire [2:0]  fDlyB    = word0_r[`LCC_DLY_B_HI:`LCC_DLY_B_LO];
	wire        fShortRm = word0_r[`LCC_SHORT_RM_BIT];
	wire [9:0]  fSeg     = word1_r[`LCC_SEG_HI:`LCC_SEG_LO];

	// derived counts
	wire [6:0]  scanNxt  = {1'b0, fScan} + 7'h01;
	wire [3:0]  subpPlus = {1'b0, fSubp} + 4'h1;
	wire [7:0]  subpNxt  = {subpPlus, 4'h0};
	wire [4:0]  multNxt  = {1'b0, fMult} + 5'h01;
	wire [10:0] segNxt   = (fSeg == `LCC_SEG_CODE_LONG) ? `LCC_SEG_LONG : `LCC_SEG_SHORT;

	// power-saving-plus threshold as a fraction of the segment length
	wire [10:0] segQuarter = {2'h0, segNxt[10:2]};
	wire [10:0] segHalf    = {1'h0, segNxt[10:1]};
	wire [10:0] segEighth  = {3'h0, segNxt[10:3]};
	wire [10:0] segSeven   = segNxt - segEighth;
	wire [10:0] pspNxt     = (fPsp == `LCC_PSP_QUARTER)   ? segQuarter :
	                         (fPsp == `LCC_PSP_HALF)      ? segHalf :
	                         (fPsp == `LCC_PSP_7_EIGHTHS) ? segSeven :
	                         `LCC_LIMIT_OFF;

	assign linkBus.ackTgl   = ackTgl_r;
	assign linkBus.pubTgl   = pubTgl_r;
	assign linkBus.pubWord0 = pubWord0_r;
	assign linkBus.pubWord1 = pubWord1_r;

	assign configWord0           = pubWord0_r;
	assign configWord1           = pubWord1_r;
	assign powerSaveEnable       = psEn_r;
	assign powerSavePlusSelect   = pspSel_r;
	assign powerSavePlusLimit    = pspLimit_r;
	assign openLedRemovalEnable  = openRm_r;
	assign scanLineCount         = scanLines_r;
	assign subperiodCount        = subperiods_r;
	assign multiplierRangeSelect = multRange_r;
	assign multiplierRatio       = multRatio_r;
	assign redGroupDelay         = dlyRed_r;
	assign greenGroupDelay       = dlyGreen_r;
	assign blueGroupDelay        = dlyBlue_r;
	assign shortLedRemovalEnable = shortRm_r;
	assign segmentCycleCount     = segCycles_r;

	// reset asserts at once and releases on the system clock
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// command toggle from the link clock, two stages before use
	always_ff @(posedge sys_clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			cmdMeta_r <= 1'b0;
			cmdSync_r <= 1'b0;
			cmdSeen_r <= 1'b0;
			ackTgl_r  <= 1'b0;
			applied_r <= 1'b0;
		end else begin
			cmdMeta_r <= linkBus.cmdTgl;
			cmdSync_r <= cmdMeta_r;
			cmdSeen_r <= cmdSync_r;
			ackTgl_r  <= cmdSeen_r;
			applied_r <= cmdEvent;
		end
	end

	always_ff @(posedge sys_clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			word0_r <= `LCC_WORD0_RESET;
			word1_r <= `LCC_WORD1_RESET;
		end else begin
			word0_r <= word0_nxt;
			word1_r <= word1_nxt;
		end
	end

	// the read image follows the stored words and is announced to the link
	always_ff @(posedge sys_clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			pubWord0_r <= `LCC_WORD0_RESET;
			pubWord1_r <= `LCC_WORD1_RESET;
			pubTgl_r   <= 1'b0;
		end else if (applied_r) begin
			pubWord0_r <= word0_r;
			pubWord1_r <= word1_r;
			pubTgl_r   <= ~pubTgl_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			psEn_r       <= 1'b0;
			pspSel_r     <= `LCC_PSP_OFF;
			pspLimit_r   <= `LCC_LIMIT_OFF;
			openRm_r     <= 1'b0;
			scanLines_r  <= `LCC_SCAN_COUNT_RESET;
			subperiods_r <= `LCC_SUBP_COUNT_RESET;
			multRange_r  <= 1'b0;
			multRatio_r  <= `LCC_RATIO_RESET;
			dlyRed_r     <= 3'h0;
			dlyGreen_r   <= 3'h0;
			dlyBlue_r    <= 3'h0;
			shortRm_r    <= 1'b0;
			segCycles_r  <= `LCC_SEG_SHORT;
		end else begin
			psEn_r       <= fPsEn;
			pspSel_r     <= fPsp;
			pspLimit_r   <= pspNxt;
			openRm_r     <= fOpenRm;
			scanLines_r  <= scanNxt;
			subperiods_r <= subpNxt;
			multRange_r  <= fRange;
			multRatio_r  <= multNxt;
			dlyRed_r     <= fDlyR;
			dlyGreen_r   <= fDlyG;
			dlyBlue_r    <= fDlyB;
			shortRm_r    <= fShortRm;
			segCycles_r  <= segNxt;
		end
	end
endmodule
`default_nettype wire

// ---- logic/lcc_map.svh ----
// command identifiers, field positions, reset values and counts of the configuration bank
`ifndef LCC_MAP_SVH
`define LCC_MAP_SVH

`define LCC_CMD_WR_WORD0   16'hAA00
`define LCC_CMD_WR_WORD1   16'hAA01
`define LCC_CMD_RD_WORD0   16'hAA60
`define LCC_CMD_RD_WORD1   16'hAA61
`define LCC_CMD_SOFT_RESET 16'hAA80

`define LCC_WORD0_RESET    48'h2000_E000_0107
`define LCC_WORD1_RESET    48'h00E0_0094_A400

`define LCC_POWER_SAVE_ENABLE_BIT      12
`define LCC_PSP_HI         14
`define LCC_PSP_LO         13
`define LCC_OPEN_RM_BIT    15
`define LCC_SCAN_HI        21
`define LCC_SCAN_LO        16
`define LCC_SUBP_HI        24
`define LCC_SUBP_LO        22
`define LCC_MULT_MODE_BIT  28
`define LCC_MULT_HI        32
`define LCC_MULT_LO        29
`define LCC_DLY_R_HI       38
`define LCC_DLY_R_LO       36
`define LCC_DLY_G_HI       41
`define LCC_DLY_G_LO       39
`define LCC_DLY_B_HI       44
`define LCC_DLY_B_LO       42
`define LCC_SHORT_RM_BIT   47
`define LCC_SEG_HI         9
`define LCC_SEG_LO         0
`define LCC_W1_RO_BIT      47

`define LCC_PSP_OFF        2'h0
`define LCC_PSP_QUARTER    2'h1
`define LCC_PSP_HALF       2'h2
`define LCC_PSP_7_EIGHTHS  2'h3

`define LCC_SEG_CODE_LONG  10'h3FF
`define LCC_SEG_LONG       11'h400
`define LCC_SEG_SHORT      11'h080
`define LCC_SUBP_STEP_LOG2 4

`define LCC_ID_BITS        5'h0F
`define LCC_DATA_BITS      6'h2F

`define LCC_SCAN_COUNT_RESET 7'h01
`define LCC_SUBP_COUNT_RESET 8'h10
`define LCC_RATIO_RESET      5'h08
`define LCC_LIMIT_OFF        11'h000

`endif

// ---- logic/lcc_pkg.sv ----
// types shared by the configuration bank and its serial link
`default_nettype none
package lcc_pkg;
	typedef logic [47:0] lcc_word_t;
	typedef logic [15:0] lcc_cmd_t;
	typedef enum logic [1:0] {LNK_IDLE, LNK_ID, LNK_WDATA, LNK_RDATA} lcc_link_state_t;
endpackage
`default_nettype wire

// ---- logic/lcc_link_if.sv ----
// crossing signals between the serial link and the register bank
`timescale 1ns/1ns
`default_nettype none
interface lcc_link_if;
	import lcc_pkg::*;
	logic      cmdTgl;
	lcc_cmd_t  cmdId;
	lcc_word_t cmdData;
	logic      ackTgl;
	logic      pubTgl;
	lcc_word_t pubWord0;
	lcc_word_t pubWord1;
	modport link (output cmdTgl, output cmdId, output cmdData, input ackTgl,
		input pubTgl, input pubWord0, input pubWord1);
	modport bank (input cmdTgl, input cmdId, input cmdData, output ackTgl,
		output pubTgl, output pubWord0, output pubWord1);
endinterface
`default_nettype wire

// ---- logic/lcc_serial_link.sv ----
// serial link front end on the link clock: frame decode, read shifter, command handshake
`timescale 1ns/1ns
`default_nettype none
`include "lcc_map.svh"
module lcc_serial_link
	import lcc_pkg::*;
(
	input  wire logic serClk,
	input  wire logic resetn,
	input  wire logic serDataIn,
	output logic      serDataOut,
	lcc_link_if.link  bus
);
	logic            rstMeta_r, rstSync_r;
	logic            ackMeta_r, ackSync_r;
	logic            pubMeta_r, pubSync_r, pubSeen_r;
	lcc_link_state_t state_r;
	logic [5:0]      cnt_r;
	lcc_cmd_t        idShift_r;
	lcc_word_t       dataShift_r;
	lcc_word_t       mirror0_r, mirror1_r;
	logic            cmdTgl_r;
	lcc_cmd_t        cmdId_r;
	lcc_word_t       cmdData_r;
	logic            serDataOut_r;

	wire lcc_cmd_t idFull   = {idShift_r[14:0], serDataIn};
	wire           lastBit  = (cnt_r == 6'h00);
	wire           busy     = (cmdTgl_r != ackSync_r);
	wire           isRead0  = (idFull == `LCC_CMD_RD_WORD0);
	wire           isRead1  = (idFull == `LCC_CMD_RD_WORD1);
	wire           isReset  = (idFull == `LCC_CMD_SOFT_RESET);
	wire           postRst  = (state_r == LNK_ID) && lastBit && isReset && !busy;
	wire           postWr   = (state_r == LNK_WDATA) && lastBit && !busy;

	assign bus.cmdTgl  = cmdTgl_r;
	assign bus.cmdId   = cmdId_r;
	assign bus.cmdData = cmdData_r;
	assign serDataOut  = serDataOut_r;

	// reset asserts at once and releases on the link clock
	always_ff @(posedge serClk or negedge resetn) begin
		if (!resetn) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	always_ff @(posedge serClk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			ackMeta_r <= 1'b0;
			ackSync_r <= 1'b0;
			pubMeta_r <= 1'b0;
			pubSync_r <= 1'b0;
			pubSeen_r <= 1'b0;
			mirror0_r <= `LCC_WORD0_RESET;
			mirror1_r <= `LCC_WORD1_RESET;
		end else begin
			ackMeta_r <= bus.ackTgl;
			ackSync_r <= ackMeta_r;
			pubMeta_r <= bus.pubTgl;
			pubSync_r <= pubMeta_r;
			pubSeen_r <= pubSync_r;
			if (pubSync_r != pubSeen_r) begin
				mirror0_r <= bus.pubWord0;
				mirror1_r <= bus.pubWord1;
			end
		end
	end

	always_ff @(posedge serClk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			state_r      <= LNK_IDLE;
			cnt_r        <= 6'h00;
			idShift_r    <= 16'h0000;
			dataShift_r  <= 48'h0000_0000_0000;
			serDataOut_r <= 1'b0;
		end else begin
			case (state_r)
				LNK_IDLE: begin
					serDataOut_r <= 1'b0;
					if (serDataIn) begin
						state_r <= LNK_ID;
						cnt_r   <= {1'b0, `LCC_ID_BITS};
					end
				end
				LNK_ID: begin
					idShift_r <= idFull;
					cnt_r     <= cnt_r - 6'h01;
					if (lastBit) begin
						cnt_r <= `LCC_DATA_BITS;
						if (isRead0 || isRead1) begin
							state_r     <= LNK_RDATA;
							dataShift_r <= isRead0 ? mirror0_r : mirror1_r;
						end else if (isReset) begin
							state_r <= LNK_IDLE;
						end else begin
							state_r <= LNK_WDATA;
						end
					end
				end
				LNK_WDATA: begin
					dataShift_r <= {dataShift_r[46:0], serDataIn};
					cnt_r       <= cnt_r - 6'h01;
					if (lastBit) begin
						state_r <= LNK_IDLE;
					end
				end
				LNK_RDATA: begin
					serDataOut_r <= dataShift_r[47];
					dataShift_r  <= {dataShift_r[46:0], 1'b0};
					cnt_r        <= cnt_r - 6'h01;
					if (lastBit) begin
						state_r <= LNK_IDLE;
					end
				end
				default: begin
					state_r <= LNK_IDLE;
				end
			endcase
		end
	end

	// a finished command is held stable until the bank toggles its acknowledge back
	always_ff @(posedge serClk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			cmdTgl_r  <= 1'b0;
			cmdId_r   <= 16'h0000;
			cmdData_r <= 48'h0000_0000_0000;
		end else if (postRst) begin
			cmdTgl_r <= ~cmdTgl_r;
			cmdId_r  <= idFull;
		end else if (postWr) begin
			cmdTgl_r  <= ~cmdTgl_r;
			cmdId_r   <= idShift_r;
			cmdData_r <= {dataShift_r[46:0], serDataIn};
		end
	end
endmodule
`default_nettype wire

// ---- test/lcc_config_regs_asserts.sv ----
// concurrent checks of the configuration bank outputs against its stored words
`timescale 1ns/1ns
`default_nettype none
`include "lcc_map.svh"
module lcc_config_regs_asserts
	import lcc_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire lcc_word_t   configWord0,
	input wire lcc_word_t   configWord1,
	input wire logic        powerSaveEnable,
	input wire logic [1:0]  powerSavePlusSelect,
	input wire logic [10:0] powerSavePlusLimit,
	input wire logic        openLedRemovalEnable,
	input wire logic [6:0]  scanLineCount,
	input wire logic [7:0]  subperiodCount,
	input wire logic        multiplierRangeSelect,
	input wire logic [4:0]  multiplierRatio,
	input wire logic [2:0]  redGroupDelay,
	input wire logic [2:0]  greenGroupDelay,
	input wire logic [2:0]  blueGroupDelay,
	input wire logic        shortLedRemovalEnable,
	input wire logic [10:0] segmentCycleCount
);
	wire logic [10:0] expSeg;
	wire logic [10:0] expLim;
	wire logic [1:0]  sel;
	assign sel = configWord0[14:13];
	assign expSeg = (configWord1[9:0] == 10'h3FF) ? 11'h400 : 11'h080;
	assign expLim = (sel == 2'h0) ? 11'h000 : (sel == 2'h1) ? expSeg >> 2 :
		(sel == 2'h2) ? expSeg >> 1 : expSeg - (expSeg >> 3);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// fields change on the same clock edge as the word images
	sequence sSettled;
		($stable(configWord0) && $stable(configWord1)) [*4];
	endsequence
	AST_POWER_SAVE: assert property (sSettled |-> powerSaveEnable == configWord0[12])
		else $error("power save enable differs from word 0");
	AST_PSP_SELECT: assert property (sSettled |-> powerSavePlusSelect == sel && powerSavePlusLimit == expLim)
		else $error("power saving plus select or limit wrong");
	AST_OPEN_REMOVAL: assert property (sSettled |-> openLedRemovalEnable == configWord0[15])
		else $error("open removal enable differs from word 0");
	AST_SCAN_LINES: assert property (sSettled |-> scanLineCount == {1'b0, configWord0[21:16]} + 7'h01)
		else $error("scan line count wrong");
	AST_SUBPERIODS: assert property (sSettled |-> subperiodCount == ({5'h00, configWord0[24:22]} + 8'h01) << 4)
		else $error("subperiod count wrong");
	AST_RANGE: assert property (sSettled |-> multiplierRangeSelect == configWord0[28])
		else $error("multiplier range differs from word 0");
	AST_RATIO: assert property (sSettled |-> multiplierRatio == {1'b0, configWord0[32:29]} + 5'h01)
		else $error("multiplier ratio wrong");
	AST_DELAYS: assert property (sSettled |-> {blueGroupDelay, greenGroupDelay, redGroupDelay} == configWord0[44:36])
		else $error("group delays differ from word 0");
	AST_SHORT_REMOVAL: assert property (sSettled |-> shortLedRemovalEnable == configWord0[47])
		else $error("short removal enable differs from word 0");
	AST_SEGMENT: assert property (sSettled |-> segmentCycleCount == expSeg)
		else $error("segment cycle count wrong");
	AST_WORD1_TOP: assert property (configWord1[47] == 1'b0)
		else $error("word 1 top bit not zero");
	AST_RESET_IMAGE: assert property ($rose(resetn) |-> configWord0 == `LCC_WORD0_RESET && multiplierRatio == 5'h08)
		else $error("reset image of word 0 wrong");
endmodule
bind lcc_config_regs lcc_config_regs_asserts lcc_config_regs_asserts_i (.sys_clk(sys_clk), .resetn(resetn),
	.configWord0(configWord0), .configWord1(configWord1), .powerSaveEnable(powerSaveEnable),
	.powerSavePlusSelect(powerSavePlusSelect), .powerSavePlusLimit(powerSavePlusLimit),
	.openLedRemovalEnable(openLedRemovalEnable), .scanLineCount(scanLineCount), .subperiodCount(subperiodCount),
	.multiplierRangeSelect(multiplierRangeSelect), .multiplierRatio(multiplierRatio), .redGroupDelay(redGroupDelay),
	.greenGroupDelay(greenGroupDelay), .blueGroupDelay(blueGroupDelay),
	.shortLedRemovalEnable(shortLedRemovalEnable), .segmentCycleCount(segmentCycleCount));
`default_nettype wire

// ---- test/lcc_ctrl_model.sv ----
// display controller model driving the serial link of the configuration bank
`timescale 1ns/1ns
`default_nettype none
module lcc_ctrl_model
	import lcc_pkg::*;
(
	output logic      serClk,
	output logic      serDataIn,
	input  wire logic serDataOut
);
	initial begin
		serClk = 1'b0;
		serDataIn = 1'b0;
		#17;
		forever begin
			#62 serClk = 1'b1;
			#63 serClk = 1'b0;
		end
	end
	// start bit then the command, most significant bit first, changed on falling edges
	task automatic header(input lcc_cmd_t id);
		@(negedge serClk) serDataIn = 1'b1;
		for (int i = 15; i >= 0; i--) @(negedge serClk) serDataIn = id[i];
	endtask
	task automatic send(input lcc_cmd_t id, input lcc_word_t d, input logic withData);
		header(id);
		if (withData)
			for (int i = 47; i >= 0; i--) @(negedge serClk) serDataIn = d[i];
		@(negedge serClk) serDataIn = 1'b0;
		// gap so the bank has taken the command before the next frame
		repeat (10) @(negedge serClk);
	endtask
	task automatic fetch(input lcc_cmd_t id, output lcc_word_t d);
		header(id);
		@(negedge serClk) serDataIn = 1'b0;
		for (int i = 47; i >= 0; i--) begin
			@(negedge serClk);
			d[i] = serDataOut;
		end
	endtask
endmodule
`default_nettype wire

// ---- test/lcc_config_regs_test.sv ----
// self-checking bench of the configuration bank driven over its serial link
`timescale 1ns/1ns
`default_nettype none
`include "lcc_map.svh"
module lcc_config_regs_test
	import lcc_pkg::*;
;
	logic        sys_clk;
	logic        resetn;
	wire logic   serClk;
	wire logic   serDataIn;
	wire logic   serDataOut;
	lcc_word_t   configWord0;
	lcc_word_t   configWord1;
	logic        powerSaveEnable;
	logic [1:0]  powerSavePlusSelect;
	logic [10:0] powerSavePlusLimit;
	logic        openLedRemovalEnable;
	logic [6:0]  scanLineCount;
	logic [7:0]  subperiodCount;
	logic        multiplierRangeSelect;
	logic [4:0]  multiplierRatio;
	logic [2:0]  redGroupDelay;
	logic [2:0]  greenGroupDelay;
	logic [2:0]  blueGroupDelay;
	logic        shortLedRemovalEnable;
	logic [10:0] segmentCycleCount;
	int          badCount;
	int          checked;
	lcc_word_t   pat0[6] = '{48'hFFFF_FFFF_FFFF, 48'h5555_5555_5555, 48'hAAAA_AAAA_AAAA,
		48'h0000_0000_6000, 48'h5555_5555_5555, 48'h0000_0000_0000};
	lcc_word_t   pat1[6] = '{48'hFFFF_FFFF_FFFF, 48'h0000_0000_03FF, 48'h0000_0000_007F,
		48'h8000_0000_0005, 48'h0000_0000_007F, 48'hAAAA_AAAA_AFFF};
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;
	lcc_config_regs lcc_config_regs_i (.sys_clk(sys_clk), .resetn(resetn), .serClk(serClk),
		.serDataIn(serDataIn), .serDataOut(serDataOut), .configWord0(configWord0), .configWord1(configWord1),
		.powerSaveEnable(powerSaveEnable), .powerSavePlusSelect(powerSavePlusSelect),
		.powerSavePlusLimit(powerSavePlusLimit), .openLedRemovalEnable(openLedRemovalEnable),
		.scanLineCount(scanLineCount), .subperiodCount(subperiodCount),
		.multiplierRangeSelect(multiplierRangeSelect), .multiplierRatio(multiplierRatio),
		.redGroupDelay(redGroupDelay), .greenGroupDelay(greenGroupDelay), .blueGroupDelay(blueGroupDelay),
		.shortLedRemovalEnable(shortLedRemovalEnable), .segmentCycleCount(segmentCycleCount));
	lcc_ctrl_model lcc_ctrl_model_i (.serClk(serClk), .serDataIn(serDataIn), .serDataOut(serDataOut));
	task automatic closeOut();
		if (badCount == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
		checked++;
		if (seen !== exp) begin
			badCount++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic checkAll(input lcc_word_t w0, input lcc_word_t w1);
		lcc_word_t   rd;
		logic [10:0] seg;
		logic [10:0] lim;
		seg = (w1[9:0] == 10'h3FF) ? 11'h400 : 11'h080;
		case (w0[14:13])
			2'h0: lim = 11'h000;
			2'h1: lim = seg >> 2;
			2'h2: lim = seg >> 1;
			default: lim = seg - (seg >> 3);
		endcase
		@(negedge sys_clk);
		check("word0", configWord0, w0);
		check("word1", configWord1, w1);
		check("powerSave", powerSaveEnable, w0[12]);
		check("pspSelect", powerSavePlusSelect, w0[14:13]);
		check("pspLimit", powerSavePlusLimit, lim);
		check("openRemoval", openLedRemovalEnable, w0[15]);
		check("scanLines", scanLineCount, w0[21:16] + 7'h01);
		check("subperiods", subperiodCount, (w0[24:22] + 8'h01) << 4);
		check("range", multiplierRangeSelect, w0[28]);
		check("ratio", multiplierRatio, w0[32:29] + 5'h01);
		check("redDelay", redGroupDelay, w0[38:36]);
		check("greenDelay", greenGroupDelay, w0[41:39]);
		check("blueDelay", blueGroupDelay, w0[44:42]);
		check("shortRemoval", shortLedRemovalEnable, w0[47]);
		check("segment", segmentCycleCount, seg);
		lcc_ctrl_model_i.fetch(`LCC_CMD_RD_WORD0, rd);
		check("read0", rd, w0);
		lcc_ctrl_model_i.fetch(`LCC_CMD_RD_WORD1, rd);
		check("read1", rd, w1);
	endtask
	initial begin
		resetn = 1'b0;
		badCount = 0;
		checked = 0;
		repeat (10) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (4) @(negedge serClk);
		checkAll(`LCC_WORD0_RESET, `LCC_WORD1_RESET);
		for (int i = 0; i < 6; i++) begin
			lcc_ctrl_model_i.send(`LCC_CMD_WR_WORD0, pat0[i], 1'b1);
			lcc_ctrl_model_i.send(`LCC_CMD_WR_WORD1, pat1[i], 1'b1);
			checkAll(pat0[i], {1'b0, pat1[i][46:0]});
		end
		lcc_ctrl_model_i.send(`LCC_CMD_SOFT_RESET, 48'h0, 1'b0);
		checkAll(`LCC_WORD0_RESET, `LCC_WORD1_RESET);
		closeOut();
	end
	initial begin
		#500000;
		badCount++;
		closeOut();
	end
endmodule
`default_nettype wire
